// ==== design/scmc_top.sv ====
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Channel mode control with a classic Wishbone register slave.
module scmc_top #(
    parameter bit LARGE_PKG = 1'b0,
    parameter int DW = scmc_pkg::SCMC_DW,
    parameter int DIV = scmc_pkg::SCMC_HALF_DIV
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial link.
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    // Interrupt.
    output logic irq_o
);
    import scmc_pkg::*;

    // Word decode, used for every register.
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    logic [15:0] mode_r;
    logic [15:0] opcfg_r;
    logic [3:0] en_r;
    logic irqf_r;
    logic mask_r;
    logic [DW-1:0] txbuf_r;
    logic txfull_r;
    logic [DW-1:0] rxd_r;
    logic irq_r;
    logic sh_ready;
    logic sh_done;
    logic [DW-1:0] sh_rx;
    logic sh_sclk;
    logic sh_mosi;

    // Bus request qualification; one access per ack.
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [3:0] ch_mask = LARGE_PKG ? SCMC_CH_LARGE : SCMC_CH_SMALL;
    wire wr_mode = wr & hit(wb_adr_i, SCMC_OFF_MODE);
    wire wr_opcfg = wr & hit(wb_adr_i, SCMC_OFF_OPCFG);
    wire wr_irqf = wr & hit(wb_adr_i, SCMC_OFF_IRQF) & wb_sel_i[0];
    wire wr_mask = wr & hit(wb_adr_i, SCMC_OFF_MASK) & wb_sel_i[0];
    wire wr_txd = wr & hit(wb_adr_i, SCMC_OFF_TXD) & wb_sel_i[0];

    // Trigger lanes; channels absent in the variant are masked off by ch_mask.
    // variant lane gating
    wire [3:0] start_v = (wr & hit(wb_adr_i, SCMC_OFF_START) & wb_sel_i[0]) ?
                         (wb_dat_i[3:0] & ch_mask) : 4'h0;
    wire [3:0] stop_v = (wr & hit(wb_adr_i, SCMC_OFF_STOP) & wb_sel_i[0]) ?
                        (wb_dat_i[3:0] & ch_mask) : 4'h0;
    wire [3:0] en_nxt = (en_r | start_v) & ~stop_v;

    // Direction bits steer what the channel may do.
    // direction decode
    wire tx_en = opcfg_r[SCMC_BIT_TXE];
    wire rx_en = opcfg_r[SCMC_BIT_RXE];
    wire ch_on = en_r[0];
    wire txd_take = wr_txd & ch_on & (tx_en | rx_en) & ~txfull_r;
    wire load_v = txfull_r & sh_ready & ch_on;

    wire irq_event = mode_r[SCMC_BIT_SRC] ? load_v : sh_done;
    wire irqf_nxt = irq_event | (wr_irqf ? wb_dat_i[SCMC_BIT_FLAG] : irqf_r);
    wire tsf = ch_on & (txfull_r | ~sh_ready);

    // Read multiplexer; trigger registers and unmapped words read zero.
    wire [31:0] rd_mux =
        hit(wb_adr_i, SCMC_OFF_MODE) ? {16'h0000, mode_r} :
        hit(wb_adr_i, SCMC_OFF_OPCFG) ? {16'h0000, opcfg_r} :
        hit(wb_adr_i, SCMC_OFF_ENABLE) ? {28'h0000000, en_r} :
        hit(wb_adr_i, SCMC_OFF_STATUS) ? (32'(tsf) << SCMC_BIT_TSF) :
        hit(wb_adr_i, SCMC_OFF_IRQF) ? {31'h00000000, irqf_r} :
        hit(wb_adr_i, SCMC_OFF_MASK) ? {31'h00000000, mask_r} :
        hit(wb_adr_i, SCMC_OFF_RXD) ? 32'(rxd_r) : 32'h00000000;

    // Bus answer: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req & ~wb_we_i) ? rd_mux : 32'h00000000;
        end
    end

    // Software-owned configuration with byte lanes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= SCMC_MODE_RST;
            opcfg_r <= SCMC_OPCFG_RST;
            mask_r <= SCMC_MASK_RST;
        end else begin
            if (wr_mode) mode_r <= (mode_r & ~wmask) | (wb_dat_i[15:0] & wmask);
            if (wr_opcfg) opcfg_r <= (opcfg_r & ~wmask) | (wb_dat_i[15:0] & wmask);
            if (wr_mask) mask_r <= wb_dat_i[SCMC_BIT_FLAG];
        end
    end

    // Enable flags, request flag and the transmit buffer.
    // A stop also empties the buffer, so a restart never sends a stale word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 4'h0;
            irqf_r <= 1'b0;
            txfull_r <= 1'b0;
            txbuf_r <= '0;
            rxd_r <= '0;
        end else begin
            en_r <= en_nxt;
            irqf_r <= irqf_nxt;
            if (txd_take) txbuf_r <= wb_dat_i[DW-1:0];
            txfull_r <= (txfull_r & ~load_v | txd_take) & en_nxt[0];
            if (sh_done && rx_en) rxd_r <= sh_rx;
        end
    end

    // Interrupt output, registered so it is glitch free.
    // mask gates request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irqf_r & ~mask_r;
        end
    end
    assign irq_o = irq_r;
    assign sclk_o = sh_sclk;
    assign mosi_o = sh_mosi;

    // Shift engine for channel 0; abort holds it idle while disabled.
    scmc_shift #(
        .DW(DW),
        .DIV(DIV)
    ) u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_v),
        .data_i(txbuf_r),
        .abort_i(~ch_on),
        .tx_en_i(tx_en),
        .ready_o(sh_ready),
        .done_o(sh_done),
        .rx_o(sh_rx),
        .sclk_o(sh_sclk),
        .mosi_o(sh_mosi),
        .miso_i(miso_i)
    );

    // Checks next to the logic they guard.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_end_irq_src: assert property (
        !mode_r[SCMC_BIT_SRC] && sh_done && !wr_irqf |=> irqf_r)
        else $error("Transfer end did not raise the request.");
    a_empty_irq_src: assert property (
        mode_r[SCMC_BIT_SRC] && load_v && !wr_irqf |=> irqf_r ##1 (sclk_o == 1'b0))
        else $error("Buffer empty did not raise the request.");
    a_flag_no_event: assert property (
        !irqf_r && !sh_done && !load_v && !wr_irqf |=> !irqf_r)
        else $error("Request flag set without an event.");
    a_start_sets_en: assert property (
        start_v[0] && !stop_v[0] |=> en_r[0] && $stable(opcfg_r))
        else $error("Start trigger did not enable the channel.");
    a_stop_clears_en: assert property (
        stop_v[0] |=> !en_r[0] && !txfull_r ##1 !sclk_o)
        else $error("Stop trigger did not halt the channel.");
    a_variant_lanes: assert property (
        (en_r & ~ch_mask) == 4'h0)
        else $error("Absent channel lane became enabled.");
    a_mask_gates_irq: assert property (
        (mask_r ##1 1'b1 |-> !irq_o) and (irqf_r && !mask_r |=> irq_o))
        else $error("Mask did not gate the interrupt output.");
    a_dir_off_no_data: assert property (
        wr_txd && !tx_en && !rx_en && !txfull_r |=> !txfull_r)
        else $error("Data accepted with communication disabled.");
    a_status_tsf: assert property (
        req && !wb_we_i && hit(wb_adr_i, SCMC_OFF_STATUS) |=>
        wb_ack_o && (wb_dat_o[SCMC_BIT_TSF] == $past(tsf)))
        else $error("Status read does not show transfer state.");
    a_disabled_no_clk: assert property (
        !en_r[0] [*2] |-> !sclk_o && sh_ready)
        else $error("Disabled channel drives the serial clock.");
endmodule

// ==== common/scmc_pkg.sv ====
package scmc_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] SCMC_OFF_MODE = 8'h00;
    localparam logic [7:0] SCMC_OFF_OPCFG = 8'h04;
    localparam logic [7:0] SCMC_OFF_START = 8'h08;
    localparam logic [7:0] SCMC_OFF_STOP = 8'h0c;
    localparam logic [7:0] SCMC_OFF_ENABLE = 8'h10;
    localparam logic [7:0] SCMC_OFF_STATUS = 8'h14;
    localparam logic [7:0] SCMC_OFF_IRQF = 8'h18;
    localparam logic [7:0] SCMC_OFF_MASK = 8'h1c;
    localparam logic [7:0] SCMC_OFF_TXD = 8'h20;
    localparam logic [7:0] SCMC_OFF_RXD = 8'h24;
    // Field positions.
    localparam int SCMC_BIT_SRC = 0;
    localparam int SCMC_BIT_TXE = 15;
    localparam int SCMC_BIT_RXE = 14;
    localparam int SCMC_BIT_TSF = 6;
    localparam int SCMC_BIT_FLAG = 0;
    // Reset values.
    localparam logic [15:0] SCMC_MODE_RST = 16'h0020;
    localparam logic [15:0] SCMC_OPCFG_RST = 16'h0007;
    localparam logic SCMC_MASK_RST = 1'h1;
    // Trigger lanes per package variant.
    localparam logic [3:0] SCMC_CH_SMALL = 4'h3;
    localparam logic [3:0] SCMC_CH_LARGE = 4'hf;
    // Data width and system clock cycles per serial clock half period.
    localparam int SCMC_DW = 8;
    localparam int SCMC_HALF_DIV = 4;
endpackage

// ==== design/scmc_shift.sv ====
`timescale 1ns/10ps
// Shift engine: one frame, MSB first, sample on rising, change on falling edge.
module scmc_shift #(
    parameter int DW = scmc_pkg::SCMC_DW,
    parameter int DIV = scmc_pkg::SCMC_HALF_DIV
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic load_i,
    input wire logic [DW-1:0] data_i,
    input wire logic abort_i,
    input wire logic tx_en_i,
    output logic ready_o,
    output logic done_o,
    output logic [DW-1:0] rx_o,
    // Serial pins.
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    import scmc_pkg::*;
    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} scmc_sh_e;
    localparam int CW = $clog2(DIV + 1);
    localparam int BW = $clog2(DW + 1);
    scmc_sh_e state_r;
    logic [CW-1:0] div_r;
    logic [BW-1:0] bits_r;
    logic [DW-1:0] tx_r;
    logic [DW-1:0] rxs_r;
    // Half-period enable pulse; the divider only runs inside a frame.
    wire tick = (div_r == CW'(DIV - 1));
    wire last = (bits_r == BW'(DW - 1));
    assign ready_o = (state_r == SH_IDLE);

    // Frame sequencer. Abort wins so a stopped channel drops the clock at once.
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i || abort_i) begin
            state_r <= SH_IDLE;
            div_r <= '0;
            sclk_o <= 1'b0;
            mosi_o <= 1'b1;
        end else begin
            div_r <= (state_r == SH_IDLE || tick) ? '0 : div_r + CW'(1);
            unique case (state_r)
                SH_IDLE: begin
                    if (load_i) begin
                        tx_r <= data_i;
                        bits_r <= '0;
                        mosi_o <= tx_en_i ? data_i[DW-1] : 1'b1;
                        state_r <= SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (tick) begin
                        sclk_o <= 1'b1;
                        rxs_r <= {rxs_r[DW-2:0], miso_i};
                        state_r <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (tick) begin
                        sclk_o <= 1'b0;
                        if (last) begin
                            rx_o <= rxs_r;
                            done_o <= 1'b1;
                            mosi_o <= 1'b1;
                            state_r <= SH_IDLE;
                        end else begin
                            tx_r <= {tx_r[DW-2:0], 1'b0};
                            mosi_o <= tx_en_i ? tx_r[DW-2] : 1'b1;
                            bits_r <= bits_r + BW'(1);
                            state_r <= SH_LOW;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ==== tb/scmc_slave_model.sv ====
`timescale 1ns/10ps
// Serial slave: takes mosi on each sclk rise and shifts its reply out MSB first.
module scmc_slave_model (
    // Control.
    input wire logic rst_i,
    input wire logic [7:0] reply_i,
    // Serial pins.
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [7:0] got_o
);
    logic [2:0] idx_r;
    // Capture on the rise, where the master samples as well.
    always @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            got_o <= 8'h00;
        end else begin
            got_o <= {got_o[6:0], mosi_i};
        end
    end
    // Advance on the fall so the next bit is stable well before the next rise.
    always @(negedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_r <= 3'h0;
        end else begin
            idx_r <= idx_r + 3'h1;
        end
    end
    assign miso_o = reply_i[3'h7 - idx_r];
endmodule

// ==== tb/serial_channel_mode_control_bench.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module serial_channel_mode_control_bench;
    import scmc_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d;} scmc_row_s;
    logic clk_i, rst_i, cyc, stb, we, ack, sclk, mosi, miso, irq, sync_rst;
    logic [7:0] adr, reply, got;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int err_count = 0;
    int samples_checked = 0;
    scmc_row_s rows[14];

    scmc_top #(.LARGE_PKG(1'b0)) scmc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_o(sclk), .mosi_o(mosi),
        .miso_i(miso), .irq_o(irq));
    scmc_slave_model scmc_slave_model_inst (.rst_i(sync_rst), .reply_i(reply),
        .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .got_o(got));

    // Free-running 20 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One classic cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("[FAIL] bus ack expected 1 seen 0");
            give_verdict();
        end
    endtask

    // A stopped or refused channel must keep its serial clock low.
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk_i);
            `CHK("sclk idle", 1'b0, sclk)
        end
    endtask

    initial begin
        cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h3; wdat = 32'h0;
        reply = 8'h3c; rst_i = 1'b1; sync_rst = 1'b1;
        rows = '{'{SCMC_OFF_MODE, 1'b0, 32'h20}, '{SCMC_OFF_OPCFG, 1'b0, 32'h7},
            '{SCMC_OFF_MASK, 1'b0, 32'h1}, '{SCMC_OFF_IRQF, 1'b0, 32'h0},
            '{SCMC_OFF_ENABLE, 1'b0, 32'h0}, '{SCMC_OFF_STATUS, 1'b0, 32'h0},
            '{8'h3c, 1'b0, 32'h0}, '{SCMC_OFF_START, 1'b1, 32'hf},
            '{SCMC_OFF_ENABLE, 1'b0, 32'h3}, '{SCMC_OFF_STOP, 1'b1, 32'h2},
            '{SCMC_OFF_ENABLE, 1'b0, 32'h1}, '{SCMC_OFF_START, 1'b1, 32'h0},
            '{SCMC_OFF_STOP, 1'b1, 32'h0}, '{SCMC_OFF_ENABLE, 1'b0, 32'h1}};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        sync_rst <= 1'b0;
        `CHK("irq after reset", 1'b0, irq)
        foreach (rows[i]) begin
            wb(rows[i].a, rows[i].w, rows[i].w ? rows[i].d : 32'h0);
            if (!rows[i].w) `CHK("register read", rows[i].d, q)
        end
        for (int k = 0; k < 4; k++) begin
            wb(SCMC_OFF_OPCFG, 1'b1, {16'h0, k[1:0], 14'h0007});
            wb(SCMC_OFF_OPCFG, 1'b0, 32'h0);
            `CHK("direction", {16'h0, k[1:0], 14'h0007}, q)
        end
        // Mask, stop, pick transfer end, then set full duplex before starting.
        wb(SCMC_OFF_MASK, 1'b1, 32'h1);
        wb(SCMC_OFF_STOP, 1'b1, 32'h1);
        wb(SCMC_OFF_MODE, 1'b1, 32'h20);
        wb(SCMC_OFF_OPCFG, 1'b1, 32'hc007);
        wb(SCMC_OFF_START, 1'b1, 32'h1);
        wb(SCMC_OFF_IRQF, 1'b1, 32'h0);
        wb(SCMC_OFF_MASK, 1'b1, 32'h0);
        wb(SCMC_OFF_TXD, 1'b1, 32'ha5);
        wb(SCMC_OFF_IRQF, 1'b0, 32'h0);
        `CHK("flag mid frame", 32'h0, q)
        wb(SCMC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("active mid frame", 1'b1, q[6])
        for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clk_i);
        `CHK("irq at frame end", 1'b1, irq)
        `CHK("slave got", 8'ha5, got)
        wb(SCMC_OFF_RXD, 1'b0, 32'h0);
        `CHK("received", 32'h3c, q)
        wb(SCMC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("active after frame", 1'b0, q[6])
        wb(SCMC_OFF_IRQF, 1'b0, 32'h0);
        `CHK("flag pending", 32'h1, q)
        wb(SCMC_OFF_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq)
        wb(SCMC_OFF_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK("irq unmasked", 1'b1, irq)
        wb(SCMC_OFF_IRQF, 1'b1, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq)
        // Buffer-empty source fires at the load, long before the last bit.
        wb(SCMC_OFF_MODE, 1'b1, 32'h21);
        wb(SCMC_OFF_TXD, 1'b1, 32'h5a);
        repeat (3) @(posedge clk_i);
        wb(SCMC_OFF_IRQF, 1'b0, 32'h0);
        `CHK("early flag", 32'h1, q)
        wb(SCMC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("still active", 1'b1, q[6])
        repeat (80) @(posedge clk_i);
        `CHK("slave got", 8'h5a, got)
        // Stop in mid frame, then a transmit write on the stopped channel.
        wb(SCMC_OFF_TXD, 1'b1, 32'hff);
        repeat (10) @(posedge clk_i);
        wb(SCMC_OFF_STOP, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        quiet(80);
        `CHK("mosi idle", 1'b1, mosi)
        wb(SCMC_OFF_TXD, 1'b1, 32'h11);
        quiet(80);
        sync_rst <= 1'b1;
        @(posedge clk_i);
        sync_rst <= 1'b0;
        // Receive only: any transmit word clocks a frame in.
        reply <= 8'h96;
        wb(SCMC_OFF_OPCFG, 1'b1, 32'h4007);
        wb(SCMC_OFF_START, 1'b1, 32'h1);
        wb(SCMC_OFF_TXD, 1'b1, 32'h0);
        repeat (80) @(posedge clk_i);
        wb(SCMC_OFF_RXD, 1'b0, 32'h0);
        `CHK("rx only", 32'h96, q)
        wb(SCMC_OFF_OPCFG, 1'b1, 32'h0007);
        wb(SCMC_OFF_TXD, 1'b1, 32'h1);
        quiet(80);
        // Transmit only: the frame goes out but the receive register keeps its byte.
        wb(SCMC_OFF_OPCFG, 1'b1, 32'h8007);
        wb(SCMC_OFF_TXD, 1'b1, 32'h69);
        repeat (80) @(posedge clk_i);
        `CHK("tx only sent", 8'h69, got)
        wb(SCMC_OFF_RXD, 1'b0, 32'h0);
        `CHK("tx only rx kept", 32'h96, q)
        // Reset in mid frame with a request pending: pins idle and registers return.
        wb(SCMC_OFF_TXD, 1'b1, 32'h33);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        sync_rst <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sync_rst <= 1'b0;
        `CHK("sclk in reset", 1'b0, sclk)
        `CHK("mosi in reset", 1'b1, mosi)
        `CHK("irq in reset", 1'b0, irq)
        for (int i = 0; i < 7; i++) begin
            wb(rows[i].a, 1'b0, 32'h0);
            `CHK("reset value", rows[i].d, q)
        end
        give_verdict();
    end
endmodule
